// File: lsis_defines.vh
// Purpose: constants for the per-link status, summary and transmit option registers
// Assumes: 11-bit byte address, link number in address bits 10:8
// Notes: definitions only
`ifndef LSIS_DEFINES_VH
`define LSIS_DEFINES_VH
`define LSIS_LINKS 8
`define LSIS_OFF_EXZ_LOW 8'h3D
`define LSIS_OFF_REF_CTRL 8'h3E
`define LSIS_OFF_LINE_SUM 8'h3F
`define LSIS_OFF_FRM_SUM 8'h40
`define LSIS_OFF_HDLC_SUM 8'h41
`define LSIS_OFF_TX_OPT 8'h42
`define LSIS_OFF_EXZ_HIGH 8'h3C
`define LSIS_OFF_INT_STAT 8'h50
`define LSIS_OFF_INT_MASK 8'h51
`define LSIS_OFF_TX_MODE 8'h52
`define LSIS_OPT_FRAME_PULSE_TYPE 0
`define LSIS_OPT_FRAME_PULSE_INVERT 1
`define LSIS_OPT_CMS 2
`define LSIS_OPT_FE 3
`define LSIS_OPT_DE 4
`define LSIS_OPT_FBIT_CLOCK_GAP 5
`define LSIS_OPT_RESET 8'h00
`define LSIS_OPT_MASK 8'h3F
`define LSIS_MODE_RESET 8'h01
`define LSIS_IS_OVF 0
`define LSIS_IS_EXZ 1
`define LSIS_IS_LOS 2
`define LSIS_DIV_HALF 3'h3
`define LSIS_FBIT_PERIOD 8'hC1
`endif

// File: lsis_link_tx.v
// Purpose: one link's transmit clock, frame pulse and reference clock output logic
// Assumes: all inputs synchronous to mclk except tx_clk_in, tx_data_in and tx_sig_in, which are synchronised
// Notes: clock outputs are registered waveforms built from mclk
`timescale 1ns/1ps
`include "lsis_defines.vh"
module lsis_link_tx (
	input wire mclk,
	input wire arst_n,
	input wire [7:0] opt,
	input wire clock_slave,
	input wire ref_hold,
	input wire los,
	input wire tx_clk_in,
	input wire tx_data_in,
	input wire tx_sig_in,
	input wire first_of_multiframe,
	output reg tx_clk_out,
	output reg tx_frame_out,
	output reg tx_data_q,
	output reg tx_sig_q,
	output reg ref_out
);
	reg ref_tgl;
	reg [2:0] div;
	reg [7:0] bitpos;
	reg gen_clk;
	reg sync1, sync2, prev;
	reg ckd1, ckd2, ckg1, ckg2;
	wire is_fbit = (bitpos == 8'h00);
	wire gen_rise = (div == `LSIS_DIV_HALF);
	wire gen_fall = (div == 3'h7);
	wire rise_edge = clock_slave ? (sync2 & ~prev) : gen_rise;
	wire fall_edge = clock_slave ? (~sync2 & prev) : gen_fall;
	wire data_edge = opt[`LSIS_OPT_DE] ? rise_edge : fall_edge;
	wire frame_edge = opt[`LSIS_OPT_FE] ? rise_edge : fall_edge;
	wire pulse_on = is_fbit & (~opt[`LSIS_OPT_FRAME_PULSE_TYPE] | first_of_multiframe);
	// -----------------------------
	// Link clock, master or slave
	// -----------------------------
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div <= 3'h0;
			bitpos <= 8'h00;
			gen_clk <= 1'b0;
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
			tx_clk_out <= 1'b0;
		end else begin
			sync1 <= tx_clk_in;
			sync2 <= sync1;
			prev <= sync2;
			div <= div + 3'h1;
			if (gen_rise)
				gen_clk <= 1'b1;
			if (gen_fall) begin
				gen_clk <= 1'b0;
				bitpos <= (bitpos == `LSIS_FBIT_PERIOD - 8'h01) ? 8'h00 : bitpos + 8'h01;
			end
			// Master drives its own clock; slave only listens, so output idles low
			if (clock_slave)
				tx_clk_out <= 1'b0;
			else
				tx_clk_out <= gen_clk & ~(opt[`LSIS_OPT_FBIT_CLOCK_GAP] & is_fbit);
		end
	end
	// -----------------------------
	// Sampling and frame pulse
	// -----------------------------
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ckd1 <= 1'b0;
			ckd2 <= 1'b0;
			ckg1 <= 1'b0;
			ckg2 <= 1'b0;
			tx_data_q <= 1'b0;
			tx_sig_q <= 1'b0;
			tx_frame_out <= 1'b0;
		end else begin
			ckd1 <= tx_data_in;
			ckd2 <= ckd1;
			ckg1 <= tx_sig_in;
			ckg2 <= ckg1;
			if (data_edge) begin
				tx_data_q <= ckd2;
				tx_sig_q <= ckg2;
			end
			if (frame_edge)
				tx_frame_out <= pulse_on ^ opt[`LSIS_OPT_FRAME_PULSE_INVERT];
		end
	end
	// -----------------------------
	// Reference clock on signal loss
	// -----------------------------
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ref_tgl <= 1'b0;
			ref_out <= 1'b0;
		end else begin
			ref_tgl <= ~ref_tgl;
			// Half-rate copy of mclk: a flop cannot pass mclk itself
			if (los && ref_hold)
				ref_out <= 1'b1;
			else
				ref_out <= ref_tgl;
		end
	end
endmodule

// File: lsis_regs.v
// Purpose: eight-link register slice with counters, interrupt summaries and tx options
// Assumes: plain register port, read data valid the cycle after the read strobe
// Notes: block interrupt flags are live inputs from other function blocks
`timescale 1ns/1ps
`include "lsis_defines.vh"
module lsis_regs (
	input wire mclk,
	input wire arst_n,
	input wire [10:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	output reg irq,
	input wire [7:0] exz_event,
	input wire [7:0] los_in,
	input wire [63:0] line_flags,
	input wire [63:0] framer_flags,
	input wire [63:0] hdlc_flags,
	input wire [7:0] mf_first,
	input wire [7:0] tx_clk_in,
	input wire [7:0] tx_data_in,
	input wire [7:0] tx_sig_in,
	output wire [7:0] tx_clk_out,
	output wire [7:0] tx_frame_out,
	output wire [7:0] tx_data_q,
	output wire [7:0] tx_sig_q,
	output wire [7:0] ref_clock_out_a,
	output wire [7:0] ref_clock_out_b
);
	wire [2:0] link = addr[10:8];
	wire [7:0] off = addr[7:0];
	reg [7:0] rmux;
	reg [7:0] lmux;
	integer k;
	genvar g;
	// -----------------------------
	// Per-link storage
	// -----------------------------
	reg [15:0] exz_cnt [0:7];
	reg [7:0] tx_opt [0:7];
	reg [7:0] tx_mode [0:7];
	reg [7:0] ref_ctrl [0:7];
	reg [7:0] int_stat [0:7];
	reg [7:0] int_mask [0:7];
	reg [7:0] line_sum;
	reg [7:0] frm_sum [0:7];
	reg [7:0] hdlc_sum [0:7];
	reg [7:0] los_q;
	reg [7:0] l1, l2, e1, e2;
	wire [7:0] pend;
	wire [7:0] exz_prev;
	wire [7:0] mux_pin_a, mux_pin_b;
	generate
		for (g = 0; g < `LSIS_LINKS; g = g + 1) begin : gl
			wire sel = (link == g);
			wire wr_hit = wr & sel;
			wire rd_hit = rd & sel;
			wire exz_edge = e2[g] & ~exz_prev[g];
			reg exz_prev_r;
			wire ovf = exz_edge & (exz_cnt[g] == 16'hFFFF);
			wire [7:0] ev;
			wire [7:0] clr_w1c;
			wire [7:0] clr_rd;
			assign ev = {5'h00, (l2[g] ^ los_q[g]), exz_edge, ovf};
			assign clr_w1c = (wr_hit && off == `LSIS_OFF_INT_STAT) ? wdata : 8'h00;
			assign clr_rd = (rd_hit && off == `LSIS_OFF_INT_STAT) ? 8'hFF : 8'h00;
			always @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					exz_cnt[g] <= 16'h0000;
					tx_opt[g] <= `LSIS_OPT_RESET;
					tx_mode[g] <= `LSIS_MODE_RESET;
					ref_ctrl[g] <= 8'h00;
					int_stat[g] <= 8'h00;
					int_mask[g] <= 8'h00;
					frm_sum[g] <= 8'h00;
					hdlc_sum[g] <= 8'h00;
					line_sum[g] <= 1'b0;
					los_q[g] <= 1'b0;
					exz_prev_r <= 1'b0;
				end else begin
					exz_prev_r <= e2[g];
					los_q[g] <= l2[g];
					if (exz_edge)
						exz_cnt[g] <= exz_cnt[g] + 16'h0001;
					// Live copies, no write needed to clear
					line_sum[g] <= |line_flags[g*8 +: 8];
					frm_sum[g] <= framer_flags[g*8 +: 8];
					hdlc_sum[g] <= hdlc_flags[g*8 +: 8];
					// Event beats a clear landing in the same cycle
					int_stat[g] <= (int_stat[g] & ~(clr_w1c | clr_rd)) | ev;
					if (wr_hit && off == `LSIS_OFF_TX_OPT)
						tx_opt[g] <= wdata & `LSIS_OPT_MASK;
					if (wr_hit && off == `LSIS_OFF_REF_CTRL)
						ref_ctrl[g] <= {7'h00, wdata[0]};
					if (wr_hit && off == `LSIS_OFF_INT_MASK)
						int_mask[g] <= {5'h00, wdata[2:0]};
					if (wr_hit && off == `LSIS_OFF_TX_MODE)
						tx_mode[g] <= {7'h00, wdata[0]};
				end
			end
			assign exz_prev[g] = exz_prev_r;
			// A set mask bit hides its status bit from the interrupt
			assign pend[g] = |(int_stat[g] & ~int_mask[g]);
			lsis_link_tx u_tx (
				.mclk(mclk),
				.arst_n(arst_n),
				.opt(tx_opt[g]),
				.clock_slave(tx_mode[g][0]),
				.ref_hold(ref_ctrl[g][0]),
				.los(los_q[g]),
				.tx_clk_in(tx_clk_in[g]),
				.tx_data_in(tx_data_in[g]),
				.tx_sig_in(tx_sig_in[g]),
				.first_of_multiframe(mf_first[g]),
				.tx_clk_out(tx_clk_out[g]),
				.tx_frame_out(tx_frame_out[g]),
				.tx_data_q(tx_data_q[g]),
				.tx_sig_q(tx_sig_q[g]),
				.ref_out(mux_pin_a[g])
			);
			assign mux_pin_b[g] = mux_pin_a[g];
		end
	endgenerate
	assign ref_clock_out_a = mux_pin_a;
	assign ref_clock_out_b = mux_pin_b;
	// -----------------------------
	// Input synchronisers
	// -----------------------------
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			l1 <= 8'h00;
			l2 <= 8'h00;
			e1 <= 8'h00;
			e2 <= 8'h00;
		end else begin
			l1 <= los_in;
			l2 <= l1;
			e1 <= exz_event;
			e2 <= e1;
		end
	end
	// -----------------------------
	// Read path
	// -----------------------------
	always @* begin
		lmux = 8'h00;
		for (k = 0; k < `LSIS_LINKS; k = k + 1)
			if (link == k)
				case (off)
				`LSIS_OFF_EXZ_LOW: lmux = exz_cnt[k][7:0];
				`LSIS_OFF_EXZ_HIGH: lmux = exz_cnt[k][15:8];
				`LSIS_OFF_REF_CTRL: lmux = ref_ctrl[k];
				`LSIS_OFF_LINE_SUM: lmux = {7'h00, line_sum[k]};
				`LSIS_OFF_FRM_SUM: lmux = frm_sum[k];
				`LSIS_OFF_HDLC_SUM: lmux = hdlc_sum[k];
				`LSIS_OFF_TX_OPT: lmux = tx_opt[k];
				`LSIS_OFF_INT_STAT: lmux = int_stat[k];
				`LSIS_OFF_INT_MASK: lmux = int_mask[k];
				`LSIS_OFF_TX_MODE: lmux = tx_mode[k];
				default: lmux = 8'h00;
				endcase
		rmux = lmux;
	end
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
			irq <= 1'b0;
		end else begin
			rdata <= rd ? rmux : 8'h00;
			irq <= |pend;
		end
	end
endmodule

// File: lsis_monitor.sv
// Purpose: read-value checks on the per-link register slice ports
// Assumes: read data registered, present only in the cycle after the read strobe
// Notes: summary flags are snapshotted at the read edge to match the registered answer
`timescale 1ns/1ps
`include "lsis_defines.vh"
module lsis_monitor (
	input wire mclk,
	input wire arst_n,
	input wire [10:0] addr,
	input wire rd,
	input wire [7:0] rdata,
	input wire [63:0] line_flags,
	input wire [63:0] framer_flags,
	input wire [63:0] hdlc_flags,
	input wire [7:0] ref_clock_out_a,
	input wire [7:0] ref_clock_out_b
);
	// ----------------------------------------
	// Snapshots and checks
	// ----------------------------------------
	reg [7:0] frm_q;
	reg [7:0] hdlc_q;
	reg [7:0] line_q;
	wire [7:0] off = addr[7:0];
	always @(posedge mclk) begin
		frm_q <= framer_flags[{addr[10:8], 3'h0} +: 8];
		hdlc_q <= hdlc_flags[{addr[10:8], 3'h0} +: 8];
		line_q <= {7'h00, |line_flags[{addr[10:8], 3'h0} +: 8]};
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_rd_frm;
		rd && off == `LSIS_OFF_FRM_SUM;
	endsequence
	sequence s_rd_hdlc;
		rd && off == `LSIS_OFF_HDLC_SUM;
	endsequence
	property p_idle_zero;
		!rd |=> rdata == 8'h00;
	endproperty
	property p_frm_sum;
		s_rd_frm |=> rdata == frm_q;
	endproperty
	property p_hdlc_sum;
		s_rd_hdlc |=> rdata == hdlc_q;
	endproperty
	property p_line_sum;
		rd && off == `LSIS_OFF_LINE_SUM |=> rdata == line_q;
	endproperty
	property p_low_unmapped;
		rd && off < 8'h3C |=> rdata == 8'h00;
	endproperty
	property p_gap_unmapped;
		rd && off > 8'h42 && off < 8'h50 |=> rdata == 8'h00;
	endproperty
	property p_top_unmapped;
		rd && off > 8'h52 |=> rdata == 8'h00;
	endproperty
	property p_ref_pair;
		ref_clock_out_a == ref_clock_out_b;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data without a read");
	a_frm_sum: assert property (p_frm_sum) else $error("framer summary wrong");
	a_hdlc_sum: assert property (p_hdlc_sum) else $error("hdlc summary wrong");
	a_line_sum: assert property (p_line_sum) else $error("line summary wrong");
	a_low_unmapped: assert property (p_low_unmapped) else $error("low hole not zero");
	a_gap_unmapped: assert property (p_gap_unmapped) else $error("mid hole not zero");
	a_top_unmapped: assert property (p_top_unmapped) else $error("top hole not zero");
	a_ref_pair: assert property (p_ref_pair) else $error("reference outputs differ");
endmodule
bind lsis_regs lsis_monitor mon_u (.mclk(mclk), .arst_n(arst_n), .addr(addr), .rd(rd),
	.rdata(rdata), .line_flags(line_flags), .framer_flags(framer_flags),
	.hdlc_flags(hdlc_flags), .ref_clock_out_a(ref_clock_out_a),
	.ref_clock_out_b(ref_clock_out_b));

// File: lsis_backplane.sv
// Purpose: system-side backplane feeding the transmit system pins in clock slave mode
// Assumes: supplied clock is mclk/4 on all links
// Notes: while run is low the clock stands low and data toggles every cycle
`timescale 1ns/1ps
module lsis_backplane (
	input wire mclk,
	input wire run,
	output reg [7:0] tx_clk_in,
	output reg [7:0] tx_data_in,
	output reg [7:0] tx_sig_in
);
	// ----------------------------------------
	// Clock and data source
	// ----------------------------------------
	reg [1:0] div;
	initial begin
		div = 2'h0;
		tx_clk_in = 8'h00;
		tx_data_in = 8'h00;
		tx_sig_in = 8'h00;
	end
	always @(posedge mclk) begin
		div <= div + 2'h1;
		if (!run) begin
			// Released lines must not look like held data
			tx_clk_in <= 8'h00;
			tx_data_in <= ~tx_data_in;
			tx_sig_in <= ~tx_sig_in;
		end else begin
			tx_clk_in <= {8{div[1]}};
			// Data moves mid low phase so either sampling edge sees it stable
			if (div == 2'h1) begin
				tx_data_in <= {tx_data_in[6:0], ~tx_data_in[7]};
				tx_sig_in <= ~tx_sig_in;
			end
		end
	end
endmodule

// File: tb_lsis_regs.sv
// Purpose: register, summary, counter, interrupt and reference clock tests
// Assumes: a set mask bit hides its status bit from the interrupt
// Notes: tx pin edge timing is only exercised, not compared
`timescale 1ns/1ps
`include "lsis_defines.vh"
module tb_lsis_regs;
	reg mclk, arst_n, wr, rd, run, prev;
	reg [10:0] addr;
	reg [7:0] wdata, exz_event, los_in;
	reg [63:0] line_flags, framer_flags, hdlc_flags;
	wire [7:0] rdata, tx_clk_in, tx_data_in, tx_sig_in, ref_a;
	wire irq;
	integer num_errors, num_checks, i;
	lsis_regs dut_u (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .exz_event(exz_event), .los_in(los_in),
		.line_flags(line_flags), .framer_flags(framer_flags), .hdlc_flags(hdlc_flags),
		.mf_first(8'h00), .tx_clk_in(tx_clk_in), .tx_data_in(tx_data_in),
		.tx_sig_in(tx_sig_in), .tx_clk_out(), .tx_frame_out(), .tx_data_q(), .tx_sig_q(),
		.ref_clock_out_a(ref_a), .ref_clock_out_b());
	lsis_backplane bp_u (.mclk(mclk), .run(run), .tx_clk_in(tx_clk_in),
		.tx_data_in(tx_data_in), .tx_sig_in(tx_sig_in));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input [7:0] got, input [7:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr_reg(input [10:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge mclk);
			wr <= 1'b0;
		end
	endtask
	task rd_chk(input [10:0] a, input [7:0] exp);
		begin
			@(posedge mclk);
			addr <= a;
			rd <= 1'b1;
			@(posedge mclk);
			rd <= 1'b0;
			#1;
			chk(rdata, exp);
		end
	endtask
	task summarize;
		begin
			$display("checks %0d errors %0d", num_checks, num_errors);
			if (num_errors == 0 && num_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#(25 * 20000);
		num_errors = num_errors + 1;
		summarize;
	end
	initial begin
		{arst_n, wr, rd, run, addr, wdata, exz_event, los_in} = 0;
		{line_flags, framer_flags, hdlc_flags} = 0;
		num_errors = 0;
		num_checks = 0;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		run <= 1'b1;
		rd_chk(11'h03D, 8'h00);
		rd_chk(11'h03E, 8'h00);
		rd_chk(11'h042, `LSIS_OPT_RESET);
		rd_chk(11'h052, `LSIS_MODE_RESET);
		wr_reg(11'h342, 8'hFF);
		rd_chk(11'h342, `LSIS_OPT_MASK);
		rd_chk(11'h542, 8'h00);
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge mclk);
			framer_flags <= 64'h1 << (9 * i);
			hdlc_flags <= 64'h80 << (7 * i);
			line_flags <= 64'h1 << (9 * i);
			rd_chk({i[2:0], `LSIS_OFF_FRM_SUM}, 8'h01 << i);
			rd_chk({i[2:0], `LSIS_OFF_HDLC_SUM}, 8'h80 >> i);
			rd_chk({i[2:0], `LSIS_OFF_LINE_SUM}, 8'h01);
			rd_chk({~i[2:0], `LSIS_OFF_FRM_SUM}, 8'h00);
		end
		@(posedge mclk);
		{line_flags, framer_flags, hdlc_flags} <= 0;
		rd_chk(11'h740, 8'h00);
		rd_chk(11'h741, 8'h00);
		rd_chk(11'h73F, 8'h00);
		repeat (5) begin
			@(posedge mclk);
			exz_event <= 8'h04;
			repeat (4) @(posedge mclk);
			exz_event <= 8'h00;
			repeat (4) @(posedge mclk);
		end
		rd_chk(11'h23D, 8'h05);
		rd_chk(11'h03D, 8'h00);
		wr_reg(11'h251, 8'hFF);
		repeat (3) @(posedge mclk);
		#1;
		chk({7'h00, irq}, 8'h00);
		wr_reg(11'h251, 8'h00);
		repeat (3) @(posedge mclk);
		#1;
		chk({7'h00, irq}, 8'h01);
		rd_chk(11'h250, 8'h02);
		repeat (3) @(posedge mclk);
		#1;
		chk({7'h00, irq}, 8'h00);
		// Hold bit set: ref_a[0] must sit high during signal loss on link 0
		wr_reg(11'h03E, 8'h01);
		los_in <= 8'h01;
		repeat (8) @(posedge mclk);
		repeat (4) begin
			@(posedge mclk);
			#1;
			chk({7'h00, ref_a[0]}, 8'h01);
		end
		wr_reg(11'h03E, 8'h00);
		repeat (4) @(posedge mclk);
		#1;
		prev = ref_a[0];
		@(posedge mclk);
		#1;
		chk({7'h00, ref_a[0]}, {7'h00, ~prev});
		rd_chk(11'h050, 8'h04);
		summarize;
	end
endmodule
